//--- group0_cmd_decoder.v
/*
 * Group-zero command decoder of a disk drive target, with an AXI4-Lite
 * register slave, a sense byte stream and a status byte handshake.
 * Assumes the drive pins are asynchronous and the fault inputs come from
 * drive logic on the same clock.
 */
// What this block does
// - Byte zero is opcode; 00, 01, 03 decoded
// - Ready drive answers all-zero status
// - Not ready drive answers Check Condition
// - Readiness test only samples ready
// - Recalibrate moves heads to block zero
// - Retries enabled cause automatic recalibrate on fault
// - Sense fetch sends exactly four bytes
// - Other received commands overwrite sense bytes with their own result
// - Sense fetch answers Check Condition only for a nonzero unit number
// - Sense meaningful mainly after Check Condition
// - Byte zero bit seven flags valid address
// - Error class in bits six to four
// - Error code in bits three to zero
// - Bytes one to three hold last address
// - Nonzero unit number gives illegal address check
// - Invalid or reserved opcode records code 20
// - Retry inhibit bit reports errors at once
`include "cmd_decoder_consts.vh"

module group0_cmd_decoder (
    input  wire        i_clock,
    input  wire        i_rst_n,
    input  wire        i_awvalid,
    output wire        o_awready,
    input  wire [4:0]  i_awaddr,
    input  wire        i_wvalid,
    output wire        o_wready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    output reg         o_bvalid,
    input  wire        i_bready,
    output reg  [1:0]  o_bresp,
    input  wire        i_arvalid,
    output wire        o_arready,
    input  wire [4:0]  i_araddr,
    output reg         o_rvalid,
    input  wire        i_rready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    input  wire        i_spindle_ready,
    input  wire        i_home_reached,
    input  wire        i_seek_fault,
    input  wire [6:0]  i_fault_code,
    input  wire [20:0] i_fault_lba,
    output reg         o_home_seek,
    output wire        o_data_valid,
    input  wire        i_data_ready,
    output wire [7:0]  o_data_byte,
    output wire        o_status_valid,
    input  wire        i_status_ready,
    output wire [7:0]  o_status_byte
);
    localparam [4:0] ST_IDLE   = 5'h01;
    localparam [4:0] ST_DECODE = 5'h02;
    localparam [4:0] ST_HOME   = 5'h04;
    localparam [4:0] ST_DATA   = 5'h08;
    localparam [4:0] ST_STATUS = 5'h10;

    reg  [4:0]  state_q;
    reg  [31:0] cdb_lo_q;
    reg  [15:0] cdb_hi_q;
    reg  [31:0] sense_q;
    reg  [31:0] shift_q;
    reg  [2:0]  count_q;
    reg  [7:0]  status_q;
    reg         inhibit_q;
    reg         auto_q;
    reg         start_q;
    wire        ready_sync;
    wire        home_sync;
    wire        write_go;
    wire        read_go;
    wire [7:0]  opcode;
    wire        unit_bad;

    // ======================================================================
    // Pin synchronisers.
    sync_two_flop #(
        .WIDTH (2)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async ({i_spindle_ready, i_home_reached}),
        .o_sync  ({ready_sync, home_sync})
    );

    // ======================================================================
    // AXI4-Lite write channel; address and data are taken together.
    assign write_go  = i_awvalid && i_wvalid && !o_bvalid;
    assign o_awready = write_go;
    assign o_wready  = write_go;

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_bvalid <= 1'b0;
            o_bresp  <= `RESP_OKAY;
            cdb_lo_q <= 32'h0000_0000;
            cdb_hi_q <= 16'h0000;
            start_q  <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
            if (write_go) begin
                o_bvalid <= 1'b1;
                o_bresp  <= `RESP_OKAY;
                case (i_awaddr)
                    `REG_CDB_LO: begin
                        if (state_q == ST_IDLE) begin
                            if (i_wstrb[0]) cdb_lo_q[7:0]   <= i_wdata[7:0];
                            if (i_wstrb[1]) cdb_lo_q[15:8]  <= i_wdata[15:8];
                            if (i_wstrb[2]) cdb_lo_q[23:16] <= i_wdata[23:16];
                            if (i_wstrb[3]) cdb_lo_q[31:24] <= i_wdata[31:24];
                        end
                    end
                    `REG_CDB_HI: begin
                        if (state_q == ST_IDLE) begin
                            if (i_wstrb[0]) cdb_hi_q[7:0]  <= i_wdata[7:0];
                            if (i_wstrb[1]) cdb_hi_q[15:8] <= i_wdata[15:8];
                        end
                    end
                    `REG_CONTROL: begin
                        start_q <= i_wstrb[0] &&
                                   i_wdata[`CTRL_START_BIT];
                    end
                    `REG_STATE, `REG_SENSE: begin
                        o_bresp <= `RESP_OKAY;
                    end
                    default: begin
                        o_bresp <= `RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // AXI4-Lite read channel.
    assign read_go   = i_arvalid && !o_rvalid;
    assign o_arready = read_go;

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= `RESP_OKAY;
        end else begin
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
            if (read_go) begin
                o_rvalid <= 1'b1;
                o_rresp  <= `RESP_OKAY;
                case (i_araddr)
                    `REG_CDB_LO:  o_rdata <= cdb_lo_q;
                    `REG_CDB_HI:  o_rdata <= {16'h0000, cdb_hi_q};
                    `REG_CONTROL: o_rdata <= 32'h0000_0000;
                    `REG_STATE:   o_rdata <= {15'h0000, ready_sync,
                                              status_q, 5'h00, auto_q,
                                              inhibit_q,
                                              state_q != ST_IDLE};
                    `REG_SENSE:   o_rdata <= sense_q;
                    default: begin
                        o_rdata <= 32'h0000_0000;
                        o_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // Command decode and execution.
    assign opcode   = cdb_lo_q[7:0];
    assign unit_bad = cdb_lo_q[8+`UNIT_MSB:8+`UNIT_LSB] != 3'h0;

    assign o_data_valid   = state_q == ST_DATA;
    assign o_data_byte    = shift_q[7:0];
    assign o_status_valid = state_q == ST_STATUS;
    assign o_status_byte  = status_q;

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_q     <= ST_IDLE;
            sense_q     <= 32'h0000_0000;
            shift_q     <= 32'h0000_0000;
            count_q     <= 3'h0;
            status_q    <= `STATUS_GOOD;
            inhibit_q   <= 1'b0;
            auto_q      <= 1'b0;
            o_home_seek <= 1'b0;
        end else begin
            o_home_seek <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_q) begin
                        state_q <= ST_DECODE;
                    end else if (i_seek_fault && !inhibit_q) begin
                        auto_q      <= 1'b1;
                        o_home_seek <= 1'b1;
                        count_q     <= `HOME_SETTLE;
                        state_q     <= ST_HOME;
                    end
                end
                ST_DECODE: begin
                    status_q <= `STATUS_GOOD;
                    if (unit_bad) begin
                        // Sense layout: valid, class, code, address.
                        sense_q  <= {24'h000000, 1'b0, `ERR_ILLEGAL_ADDR};
                        status_q <= `STATUS_CHECK;
                        state_q  <= ST_STATUS;
                    end else begin
                        case (opcode)
                            `OP_READY_TEST: begin
                                // Only the ready level is sampled.
                                if (ready_sync) begin
                                    sense_q  <= 32'h0000_0000;
                                    status_q <= `STATUS_GOOD;
                                end else begin
                                    sense_q  <= {24'h000000, 1'b0,
                                                 `ERR_NOT_READY};
                                    status_q <= `STATUS_CHECK;
                                end
                                state_q <= ST_STATUS;
                            end
                            `OP_RECALIBRATE: begin
                                sense_q     <= 32'h0000_0000;
                                inhibit_q   <=
                                    cdb_hi_q[8+`RETRY_INHIBIT_BIT];
                                auto_q      <= 1'b0;
                                o_home_seek <= 1'b1;
                                count_q     <= `HOME_SETTLE;
                                state_q     <= ST_HOME;
                            end
                            `OP_SENSE_FETCH: begin
                                shift_q  <= sense_q;
                                count_q  <= 3'h0;
                                status_q <= `STATUS_GOOD;
                                state_q  <= ST_DATA;
                            end
                            default: begin
                                sense_q  <= {24'h000000, 1'b0,
                                             `ERR_INVALID_CMD};
                                status_q <= `STATUS_CHECK;
                                state_q  <= ST_STATUS;
                            end
                        endcase
                    end
                end
                ST_HOME: begin
                    if (count_q != 3'h0) begin
                        count_q <= count_q - 3'h1;
                    end
                    if (i_seek_fault) begin
                        if (inhibit_q || auto_q) begin
                            // Fault reported at once with its address.
                            sense_q  <= {i_fault_lba[7:0],
                                i_fault_lba[15:8], 3'h0,
                                i_fault_lba[20:16],
                                1'b1,
                                i_fault_code[6:4] & 3'h3,
                                i_fault_code[3:0]};
                            status_q <= `STATUS_CHECK;
                            state_q  <= auto_q ? ST_IDLE : ST_STATUS;
                            auto_q   <= 1'b0;
                        end else begin
                            auto_q      <= 1'b1;
                            o_home_seek <= 1'b1;
                            count_q     <= `HOME_SETTLE;
                        end
                    end else if (home_sync && count_q == 3'h0) begin
                        state_q <= auto_q ? ST_IDLE : ST_STATUS;
                        auto_q  <= 1'b0;
                    end
                end
                ST_DATA: begin
                    if (i_data_ready) begin
                        shift_q <= {8'h00, shift_q[31:8]};
                        count_q <= count_q + 3'h1;
                        if (count_q == `SENSE_BYTES - 3'h1) begin
                            state_q <= ST_STATUS;
                        end
                    end
                end
                ST_STATUS: begin
                    if (i_status_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- cmd_decoder_consts.vh
/*
 * Constants for the group-zero disk command decoder: register byte
 * offsets, field positions, opcodes, status bytes and sense codes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef CMD_DECODER_CONSTS_VH
`define CMD_DECODER_CONSTS_VH

// ==========================================================================
// Register byte offsets on the AXI4-Lite slave.
`define REG_CDB_LO          5'h00
`define REG_CDB_HI          5'h04
`define REG_CONTROL         5'h08
`define REG_STATE           5'h0C
`define REG_SENSE           5'h10

// ==========================================================================
// Control register fields.
`define CTRL_START_BIT      0

// ==========================================================================
// Command block fields.
`define OP_READY_TEST       8'h00
`define OP_RECALIBRATE      8'h01
`define OP_SENSE_FETCH      8'h03
`define UNIT_MSB            7
`define UNIT_LSB            5
`define RETRY_INHIBIT_BIT   7

// ==========================================================================
// Status bytes and sense fields.
`define STATUS_GOOD         8'h00
`define STATUS_CHECK        8'h02
`define SENSE_VALID_BIT     7
`define ERR_NONE            7'h00
`define ERR_NOT_READY       7'h04
`define ERR_INVALID_CMD     7'h20
`define ERR_ILLEGAL_ADDR    7'h21
`define SENSE_BYTES         3'h4

// ==========================================================================
// Cycles the home input is ignored after a seek order.
`define HOME_SETTLE         3'h3

// ==========================================================================
// AXI responses.
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

//--- sync_two_flop.v
/*
 * Two-flop synchroniser for a group of unrelated level inputs.
 * Assumes each bit is a slow level from outside the clock domain.
 */
module sync_two_flop #(
    parameter WIDTH = 1
) (
    input  wire             i_clock,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // ======================================================================
    // Synchroniser chain.
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

//--- cmd_decoder_chk.sv
/* Checker for the group-zero command decoder's sense and status outputs.
   Assumes it is bound to the top module and sees only its ports. */
// ====================
// Port checks.
module cmd_decoder_chk (
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       o_home_seek,
    input wire logic       o_data_valid,
    input wire logic       i_data_ready,
    input wire logic [7:0] o_data_byte,
    input wire logic       o_status_valid,
    input wire logic       i_status_ready,
    input wire logic [7:0] o_status_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic [2:0] cnt_q;
    wire take = o_data_valid && i_data_ready;
    // Counts sense bytes taken since the last status phase.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || o_status_valid)
            cnt_q <= 3'h0;
        else if (take)
            cnt_q <= cnt_q + 3'h1;
    end
    sequence s_last_take;
        take && cnt_q == 3'h3;
    endsequence
    sequence s_good_status;
        ##[0:3] (o_status_valid && o_status_byte == 8'h00);
    endsequence
    a_four_then_good: assert property (s_last_take |=>
        (!o_data_valid throughout s_good_status))
        else $error("sense stream length or status wrong");
    a_class_range: assert property (
        o_data_valid && cnt_q == 3'h0 |-> !o_data_byte[6])
        else $error("error class above three");
    a_lba_reserved: assert property (
        o_data_valid && cnt_q == 3'h1 |-> o_data_byte[7:5] == 3'h0)
        else $error("reserved sense bits set");
    a_data_hold: assert property (o_data_valid && !i_data_ready
        |=> o_data_valid && $stable(o_data_byte))
        else $error("sense byte dropped before taken");
    a_status_hold: assert property (o_status_valid && !i_status_ready
        |=> o_status_valid && $stable(o_status_byte))
        else $error("status dropped before taken");
    a_status_code: assert property (o_status_valid |->
        o_status_byte == 8'h00 || o_status_byte == 8'h02)
        else $error("status byte not good or check");
    a_phase_apart: assert property (
        !(o_data_valid && o_status_valid))
        else $error("data and status phases overlap");
    a_home_pulse: assert property (o_home_seek |=> !o_home_seek)
        else $error("home seek longer than one cycle");
endmodule
bind group0_cmd_decoder cmd_decoder_chk chk (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .o_home_seek(o_home_seek),
    .o_data_valid(o_data_valid), .i_data_ready(i_data_ready),
    .o_data_byte(o_data_byte), .o_status_valid(o_status_valid),
    .i_status_ready(i_status_ready), .o_status_byte(o_status_byte));

//--- initiator_model.sv
/* Initiator model: takes sense bytes and status from the decoder.
   Assumes valid levels hold until taken; i_slow makes it stall. */
// ====================
// Initiator side.
module initiator_model (
    input  wire logic       i_clock,
    input  wire logic       i_slow,
    input  wire logic       i_data_valid,
    output logic            o_data_ready,
    input  wire logic [7:0] i_data_byte,
    input  wire logic       i_status_valid,
    output logic            o_status_ready,
    input  wire logic [7:0] i_status_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] byte_q[$];
    logic [7:0] stat;
    logic [1:0] ph;
    int         n_stat;
    initial begin
        {o_data_ready, o_status_ready, ph, stat} = '0;
        n_stat = 0;
    end
    // Takes every offered byte, stalling three cycles of four when slow.
    always @(posedge i_clock) begin
        ph <= ph + 2'h1;
        o_data_ready <= !i_slow || ph == 2'h0;
        o_status_ready <= !i_slow || ph == 2'h1;
        if (i_data_valid && o_data_ready)
            byte_q.push_back(i_data_byte);
        if (i_status_valid && o_status_ready) begin
            stat <= i_status_byte;
            n_stat <= n_stat + 1;
        end
    end
endmodule

//--- testbench.sv
/* Testbench for the group-zero command decoder.
   Assumes the initiator model and the bound checker. */
`include "cmd_decoder_consts.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    error_cnt++; $display("Error %s exp %h got %h", n, e, g); end end
`define WAITN(c) k = 0; do begin @(negedge i_clock); k++; end \
    while (!(c) && k < 500); if (!(c)) end_of_test(1'b1);
// ====================
// Bench.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clock, i_rst_n, i_awvalid, i_wvalid, i_bready;
    logic        i_arvalid, i_rready, i_spindle_ready, i_seek_fault;
    logic        i_slow, arm, kick;
    logic [4:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata, d;
    logic [3:0]  i_wstrb, hcnt;
    logic [6:0]  i_fault_code;
    logic [20:0] i_fault_lba;
    logic [15:0] rnd;
    logic [7:0]  st;
    logic [1:0]  r;
    wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire         o_home_seek, o_data_valid, o_status_valid;
    wire         i_data_ready, i_status_ready, i_home_reached;
    wire [1:0]   o_bresp, o_rresp;
    wire [31:0]  o_rdata;
    wire [7:0]   o_data_byte, o_status_byte;
    int          error_cnt, n_tests, k, hpulse, h0;
    group0_cmd_decoder dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_rdata(o_rdata), .o_rresp(o_rresp),
        .i_spindle_ready(i_spindle_ready), .i_home_reached(i_home_reached),
        .i_seek_fault(i_seek_fault), .i_fault_code(i_fault_code),
        .i_fault_lba(i_fault_lba), .o_home_seek(o_home_seek),
        .o_data_valid(o_data_valid), .i_data_ready(i_data_ready),
        .o_data_byte(o_data_byte), .o_status_valid(o_status_valid),
        .i_status_ready(i_status_ready), .o_status_byte(o_status_byte));
    initiator_model pm (.i_clock(i_clock), .i_slow(i_slow),
        .i_data_valid(o_data_valid), .o_data_ready(i_data_ready),
        .i_data_byte(o_data_byte), .i_status_valid(o_status_valid),
        .o_status_ready(i_status_ready), .i_status_byte(o_status_byte));
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    // Heads leave home on a seek order and come back eight cycles later.
    assign i_home_reached = (hcnt == 4'h0);
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            {i_seek_fault, hcnt, hpulse} <= '0;
        end else begin
            i_seek_fault <= kick || (arm && hcnt == 4'h3);
            if (o_home_seek) begin
                hcnt <= 4'h8;
                hpulse <= hpulse + 1;
            end else if (hcnt != 4'h0)
                hcnt <= hcnt - 4'h1;
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [31:0] sense_of(input logic [6:0] c,
                                             input logic [20:0] a);
        return {a[7:0], a[15:8], 3'h0, a[20:16], 1'b1, c};
    endfunction
    task automatic end_of_test(input bit to);
        if (to)
            error_cnt++;
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] w);
        @(posedge i_clock);
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_awaddr <= a;
        i_wdata <= w;
        `WAITN(o_awready && o_wready)
        @(posedge i_clock);
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        i_bready <= 1'b1;
        `WAITN(o_bvalid)
        @(posedge i_clock);
        r = o_bresp;
        i_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [4:0] a);
        @(posedge i_clock);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        `WAITN(o_arready)
        @(posedge i_clock);
        i_arvalid <= 1'b0;
        i_rready <= 1'b1;
        `WAITN(o_rvalid)
        @(posedge i_clock);
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
    endtask
    task automatic cmd(input logic [31:0] lo, input logic [31:0] hi);
        int s0;
        s0 = pm.n_stat;
        pm.byte_q.delete();
        axi_wr(`REG_CDB_LO, lo);
        axi_wr(`REG_CDB_HI, hi);
        axi_wr(`REG_CONTROL, 32'h1);
        `WAITN(pm.n_stat != s0)
        st = pm.stat;
    endtask
    task automatic fetch(input logic [31:0] e);
        axi_rd(`REG_SENSE);
        `CHK("sense reg", e, d)
        cmd({24'h0, `OP_SENSE_FETCH}, 32'h0);
        `CHK("count", 4, pm.byte_q.size())
        `CHK("sense", e, {pm.byte_q[3], pm.byte_q[2], pm.byte_q[1],
            pm.byte_q[0]})
        `CHK("fetch status", `STATUS_GOOD, st)
    endtask
    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        {arm, kick, i_slow, i_spindle_ready} = '0;
        {i_awaddr, i_araddr, i_wdata, i_fault_lba} = '0;
        {i_rst_n, error_cnt, n_tests} = '0;
        i_wstrb = 4'hF;
        i_fault_code = 7'h15;
        rnd = 16'hFB07;
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'b1;
        axi_rd(`REG_SENSE);
        `CHK("sense reset", 32'h0, d)
        axi_rd(5'h14);
        `CHK("unmapped", `RESP_SLVERR, r)
        $display("reset test done");
        cmd(32'h0, 32'h0);
        `CHK("not ready", `STATUS_CHECK, st)
        fetch({25'h0, `ERR_NOT_READY});
        @(posedge i_clock);
        i_spindle_ready <= 1'b1;
        i_slow <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            cmd({rnd, 3'h0, rnd[4:0], 8'h0}, {16'h0, rnd});
            `CHK("ready", `STATUS_GOOD, st)
        end
        `CHK("no seek", 0, hpulse)
        fetch(32'h0);
        for (int op = 2; op < 32; op++) begin
            if (op == 2 || op == 8 || op == 9 || op > 16) begin
                cmd({24'h0, 8'(op)}, 32'h0);
                `CHK("opcode", `STATUS_CHECK, st)
                fetch({25'h0, `ERR_INVALID_CMD});
            end
        end
        i_slow <= 1'b0;
        $display("opcode test done");
        cmd(32'h0000_A000, 32'h0);
        `CHK("unit", `STATUS_CHECK, st)
        fetch({25'h0, `ERR_ILLEGAL_ADDR});
        h0 = hpulse;
        cmd({24'h0, `OP_RECALIBRATE}, 32'h0000_8000);
        `CHK("recal", `STATUS_GOOD, st)
        `CHK("home", h0 + 1, hpulse)
        rnd = lfsr(rnd);
        @(posedge i_clock);
        i_fault_lba <= {5'h13, rnd};
        arm <= 1'b1;
        cmd({24'h0, `OP_RECALIBRATE}, 32'h0000_8000);
        arm <= 1'b0;
        `CHK("fault", `STATUS_CHECK, st)
        fetch(sense_of(7'h15, {5'h13, rnd}));
        cmd({24'h0, `OP_RECALIBRATE}, 32'h0);
        h0 = hpulse;
        kick <= 1'b1;
        @(posedge i_clock);
        kick <= 1'b0;
        `WAITN(hpulse != h0)
        `CHK("auto home", h0 + 1, hpulse)
        for (int j = 0; j < 20; j++) begin
            axi_rd(`REG_STATE);
            if (!d[2])
                break;
        end
        `CHK("auto done", 1'b0, d[2])
        $display("recalibrate test done");
        end_of_test(1'b0);
    end
endmodule
